// ===== rtl/safety_di_consts.vh
// Purpose: Shared constants of the dual channel safety input diagnostics
// Assumes: 25 MHz core clock
// Notes: Times kept in their own unit, clock counts derived from them
`ifndef SAFETY_DI_CONSTS_VH
`define SAFETY_DI_CONSTS_VH

`define CLK_KHZ 25000
`define MODCYC_MS 15
`define MODCYC_CLKS (`MODCYC_MS * `CLK_KHZ)
`define INTER_MS 60
`define INTER_MODCYC (`INTER_MS / `MODCYC_MS)
`define PO_PROC_MS 5100
`define PO_PROC_CLKS (`PO_PROC_MS * `CLK_KHZ)
`define PO_SYS_MS 25000
`define PO_SYS_CLKS (`PO_SYS_MS * `CLK_KHZ)
`define LT_HOURS 8
// Strictly shorter than the limit, counted in module cycles
`define LT_MODCYC ((`LT_HOURS * 3600 * 1000) / `MODCYC_MS - 1)
`define SOLO_MODCYC 4000
`define SETTLE_CLKS 8'h08

`define FRAME_MAX_BITS 160
`define FRAME_DATA_BITS 96
`define FRAME_CRC_BITS 32
`define FRAME_LAST_BIT 8'h7f
`define FRAME_CRC_FIRST 8'h60
`define CRC_POLY 32'h04c11db7
`define CRC_INIT 32'hffffffff

`define ST_RUNNING 7
`define ST_FALLBACK 6
`define ST_CROSS 5
`define ST_DPM 4
`define ST_LONGTERM 3
`define ST_PROCSUP 2
`define ST_SENSSUP 1
`define ST_POFAIL 0

`endif

// ===== rtl/pin_sync3.v
// Purpose: Three stage synchroniser for a vector of pins
// Assumes: Pins are asynchronous to core_clk
// Notes: A change is taken once stages two and three agree
`timescale 1ns/1ps
module pin_sync3 #(
  parameter W = 8
) (
  // Clock and reset
  input wire core_clk,
  input wire rst,
  // Pins and clean copy
  input wire [W-1:0] din,
  output reg [W-1:0] dout
);
  genvar i;
  generate
    for (i = 0; i < W; i = i + 1) begin : g_bit
      reg s1;
      reg s2;
      reg s3;
      always @(posedge core_clk) begin
        if (rst) begin
          s1 <= 1'b0;
          s2 <= 1'b0;
          s3 <= 1'b0;
          dout[i] <= 1'b0;
        end else begin
          s1 <= din[i];
          s2 <= s1;
          s3 <= s2;
          // Filters a one-cycle glitch in stage two
          if (s2 == s3) begin
            dout[i] <= s3;
          end
        end
      end
    end
  endgenerate
endmodule // pin_sync3

// ===== rtl/frame_crc32.v
// Purpose: Serial CRC-32 over the response frame bits
// Assumes: One bit per clock while en is high
// Notes: No final inversion; register is read directly
`timescale 1ns/1ps
`include "safety_di_consts.vh"
module frame_crc32 (
  // Clock and reset
  input wire core_clk,
  input wire rst,
  // Bit stream
  input wire init,
  input wire en,
  input wire bitIn,
  output reg [31:0] crc
);
  wire fb;
  assign fb = crc[31] ^ bitIn;
  always @(posedge core_clk) begin
    if (rst || init) begin
      crc <= `CRC_INIT;
    end else if (en) begin
      crc <= {crc[30:0], 1'b0} ^ (fb ? `CRC_POLY : 32'h00000000);
    end
  end
endmodule // frame_crc32

// ===== rtl/dual_channel_safety_input_diag.v
// Purpose: Acquisition, voting, self-test and health of a two-system safety input module
// Assumes: Both measuring chains, leak sense, supplies and strap pins are asynchronous; results of the
//   micro-level checks (power-on, long-term, peer sequence, memory copies) are on core_clk
// Notes: Faults latch until reset, except open wire, chain discrepancy and supply status, which follow the pins; a safety reaction never clears itself
`timescale 1ns/1ps
`include "safety_di_consts.vh"
module dual_channel_safety_input_diag #(
  parameter NCH = 16,
  parameter MODCYC_CLKS = `MODCYC_CLKS,
  parameter PO_PROC_CLKS = `PO_PROC_CLKS,
  parameter PO_SYS_CLKS = `PO_SYS_CLKS,
  parameter LT_MODCYC = `LT_MODCYC,
  parameter SOLO_MODCYC = `SOLO_MODCYC,
  parameter INTER_MODCYC = `INTER_MODCYC,
  // Arbitrary value, not tied to any real part
  parameter [15:0] MODULE_ID = 16'h5a3c
) (
  // Clock and reset
  input wire core_clk,
  input wire rst,
  // Sample streams of the two measuring chains
  input wire [NCH-1:0] chainA,
  input wire [NCH-1:0] chainB,
  input wire [NCH-1:0] leakSense,
  // Supply supervisors and slot strap
  input wire sensorSupplyA,
  input wire sensorSupplyB,
  input wire procSupplyA,
  input wire procSupplyB,
  input wire backplaneOver,
  input wire backplaneUnder,
  input wire [7:0] slotAddr,
  // Results from the processing systems
  input wire procTestOk,
  input wire sysTestOk,
  input wire peerSeqOkA,
  input wire peerSeqOkB,
  input wire ltDone,
  input wire ltClockOk,
  input wire ltMemOk,
  input wire ltCtrlOk,
  // Dual-port memory comparison
  input wire dpmAccess,
  input wire [15:0] dpmWordA,
  input wire [15:0] dpmWordB,
  // Serializer and deserializer control
  output reg sampleStrobe,
  output reg [NCH-1:0] forceEnA,
  output reg [NCH-1:0] forceEnB,
  output reg forceLevel,
  output reg ltStart,
  // Status
  output reg running,
  output reg fallback,
  output reg moduleHealthy,
  output reg [NCH-1:0] inputWord,
  output reg [NCH-1:0] healthWord,
  output reg [NCH-1:0] diagFault,
  output reg [NCH-1:0] openWire,
  // Response frame
  output reg frameStart,
  output reg frameValid,
  output reg frameData
);
  localparam SW = 3 * NCH + 14;
  localparam S_IDLE = 3'd0;
  localparam S_SAMPLE = 3'd1;
  localparam S_FORCE = 3'd2;
  localparam S_VOTE = 3'd3;
  localparam S_SEND = 3'd4;

  // Synchronised pins
  wire [SW-1:0] syncOut;
  wire [NCH-1:0] cA;
  wire [NCH-1:0] cB;
  wire [NCH-1:0] leak;
  wire sensA;
  wire sensB;
  wire procA;
  wire procB;
  wire bpOver;
  wire bpUnder;
  wire [7:0] addr;

  pin_sync3 #(.W(SW)) u_sync (
    .core_clk(core_clk),
    .rst(rst),
    .din({chainA, chainB, leakSense, sensorSupplyA, sensorSupplyB, procSupplyA,
          procSupplyB, backplaneOver, backplaneUnder, slotAddr}),
    .dout(syncOut)
  );
  assign {cA, cB, leak, sensA, sensB, procA, procB, bpOver, bpUnder, addr} = syncOut;

  reg [31:0] poProcCnt;
  reg [31:0] poSysCnt;
  reg poFailed;
  reg [31:0] cycTimer;
  reg modTick;
  reg [2:0] state;
  reg [7:0] waitCnt;
  reg phase;
  reg testA;
  reg testB;
  reg soloCycle;
  reg soloSys;
  reg [15:0] interCnt;
  reg [15:0] soloCnt;
  reg [31:0] ltCnt;
  reg ltSeen;
  reg ltFault;
  reg dpmFault;
  reg crossFault;
  reg [NCH-1:0] sampA;
  reg [NCH-1:0] sampB;
  reg [NCH-1:0] leakCap;
  reg [31:0] timestamp;
  reg [95:0] shreg;
  reg [7:0] bitCnt;
  // Combinational, so the CRC takes each data bit on the edge that sends it
  wire crcInit = (state == S_VOTE);
  wire crcEn = (state == S_SEND) && (bitCnt < `FRAME_CRC_FIRST);
  wire [31:0] crcOut;

  // Voting and health of the captured samples
  wire supplyOk = sensA & sensB;
  wire procOk = procA & procB;
  wire healthyNow = running & ~fallback & ~crossFault & ~dpmFault & ~ltFault & procOk;
  wire [NCH-1:0] measSolo = soloSys ? sampA : sampB;
  wire [NCH-1:0] agree = soloCycle ? {NCH{1'b1}} : ~(sampA ^ sampB);
  // Outside solo cycles a one is reported only when both chains see it, so any doubt trips
  wire [NCH-1:0] votedVal = soloCycle ? measSolo : (sampA & sampB);
  wire [NCH-1:0] next_inputWord = (running & ~fallback & supplyOk) ? votedVal
                                  : {NCH{1'b0}};
  wire [NCH-1:0] next_healthWord = (healthyNow & supplyOk)
                                   ? (agree & leakCap & ~diagFault) : {NCH{1'b0}};
  wire [7:0] status = {running, fallback, crossFault, dpmFault, ltFault, procOk,
                       supplyOk, poFailed};
  wire [NCH-1:0] forcedExp = {NCH{forceLevel}};
  wire [NCH-1:0] failA = testA ? (cA ^ forcedExp) : {NCH{1'b0}};
  wire [NCH-1:0] failB = testB ? (cB ^ forcedExp) : {NCH{1'b0}};

  frame_crc32 u_crc (
    .core_clk(core_clk),
    .rst(rst),
    .init(crcInit),
    .en(crcEn),
    .bitIn(shreg[95]),
    .crc(crcOut)
  );

  // Power-on self-test and fallback
  always @(posedge core_clk) begin
    if (rst) begin
      poProcCnt <= 32'h00000000;
      poSysCnt <= 32'h00000000;
      running <= 1'b0;
      poFailed <= 1'b0;
      fallback <= 1'b0;
    end else begin
      // Without field supply the tests do not take place
      if (!supplyOk && !running) begin
        poProcCnt <= 32'h00000000;
        poSysCnt <= 32'h00000000;
      end else begin
        if (poProcCnt != PO_PROC_CLKS) begin
          poProcCnt <= poProcCnt + 32'h00000001;
        end
        if (poSysCnt != PO_SYS_CLKS) begin
          poSysCnt <= poSysCnt + 32'h00000001;
        end
      end
      if (!running && !poFailed && poProcCnt == PO_PROC_CLKS && poSysCnt == PO_SYS_CLKS) begin
        if (procTestOk && sysTestOk) begin
          running <= 1'b1;
        end else begin
          poFailed <= 1'b1;
        end
      end
      if (bpOver || bpUnder) begin
        fallback <= 1'b1;
      end
    end
  end

  // Module cycle timebase, long-term schedule, memory compare
  always @(posedge core_clk) begin
    if (rst) begin
      cycTimer <= 32'h00000000;
      modTick <= 1'b0;
      ltCnt <= 32'h00000000;
      ltSeen <= 1'b0;
      ltFault <= 1'b0;
      ltStart <= 1'b0;
      dpmFault <= 1'b0;
      moduleHealthy <= 1'b0;
    end else begin
      modTick <= 1'b0;
      ltStart <= 1'b0;
      if (running && !fallback) begin
        if (cycTimer == MODCYC_CLKS - 1) begin
          cycTimer <= 32'h00000000;
          modTick <= 1'b1;
        end else begin
          cycTimer <= cycTimer + 32'h00000001;
        end
      end
      if (modTick) begin
        if (ltCnt == LT_MODCYC - 1) begin
          ltCnt <= 32'h00000000;
          ltSeen <= 1'b0;
          if (!ltSeen) begin
            ltFault <= 1'b1;
          end
        end else begin
          ltCnt <= ltCnt + 32'h00000001;
        end
        ltStart <= (ltCnt == 32'h00000000);
      end
      if (ltDone) begin
        if (ltClockOk && ltMemOk && ltCtrlOk) begin
          ltSeen <= 1'b1;
        end else begin
          ltFault <= 1'b1;
        end
      end
      if (dpmAccess && dpmWordA != dpmWordB) begin
        dpmFault <= 1'b1;
      end
      moduleHealthy <= healthyNow;
    end
  end

  // Cycle sequencer: sample, optional forcing test, vote, send
  always @(posedge core_clk) begin
    if (rst) begin
      state <= S_IDLE;
      waitCnt <= 8'h00;
      phase <= 1'b0;
      testA <= 1'b0;
      testB <= 1'b0;
      soloCycle <= 1'b0;
      soloSys <= 1'b0;
      interCnt <= 16'h0000;
      soloCnt <= 16'h0000;
      crossFault <= 1'b0;
      sampA <= {NCH{1'b0}};
      sampB <= {NCH{1'b0}};
      leakCap <= {NCH{1'b0}};
      timestamp <= 32'h00000000;
      shreg <= 96'h0;
      bitCnt <= 8'h00;
      sampleStrobe <= 1'b0;
      forceEnA <= {NCH{1'b0}};
      forceEnB <= {NCH{1'b0}};
      forceLevel <= 1'b0;
      inputWord <= {NCH{1'b0}};
      healthWord <= {NCH{1'b0}};
      diagFault <= {NCH{1'b0}};
      openWire <= {NCH{1'b0}};
      frameStart <= 1'b0;
      frameValid <= 1'b0;
      frameData <= 1'b0;
    end else begin
      sampleStrobe <= 1'b0;
      frameStart <= 1'b0;
      // A new cycle tick while still busy means the timing went astray
      if (modTick && state != S_IDLE) begin
        crossFault <= 1'b1;
      end
      if (fallback) begin
        inputWord <= {NCH{1'b0}};
        healthWord <= {NCH{1'b0}};
      end
      case (state)
        S_IDLE: begin
          frameValid <= 1'b0;
          if (modTick) begin
            soloCycle <= (soloCnt == SOLO_MODCYC - 1);
            testA <= 1'b0;
            testB <= 1'b0;
            if (soloCnt == SOLO_MODCYC - 1) begin
              soloCnt <= 16'h0000;
              soloSys <= ~soloSys;
              testA <= soloSys;
              testB <= ~soloSys;
            end else begin
              soloCnt <= soloCnt + 16'h0001;
            end
            if (interCnt == INTER_MODCYC - 1) begin
              interCnt <= 16'h0000;
              if (soloCnt != SOLO_MODCYC - 1) begin
                testA <= 1'b1;
                testB <= 1'b1;
              end
            end else begin
              interCnt <= interCnt + 16'h0001;
            end
            sampleStrobe <= 1'b1;
            waitCnt <= 8'h00;
            state <= S_SAMPLE;
          end
        end
        S_SAMPLE: begin
          if (waitCnt == `SETTLE_CLKS) begin
            // Both chains captured on the same edge
            sampA <= cA;
            sampB <= cB;
            leakCap <= leak;
            openWire <= ~leak;
            waitCnt <= 8'h00;
            phase <= 1'b0;
            forceLevel <= 1'b0;
            if (testA || testB) begin
              forceEnA <= {NCH{testA}};
              forceEnB <= {NCH{testB}};
              state <= S_FORCE;
            end else begin
              state <= S_VOTE;
            end
          end else begin
            waitCnt <= waitCnt + 8'h01;
          end
        end
        S_FORCE: begin
          if (waitCnt == `SETTLE_CLKS) begin
            diagFault <= diagFault | failA | failB;
            waitCnt <= 8'h00;
            if (!phase) begin
              phase <= 1'b1;
              forceLevel <= 1'b1;
            end else begin
              forceEnA <= {NCH{1'b0}};
              forceEnB <= {NCH{1'b0}};
              forceLevel <= 1'b0;
              state <= S_VOTE;
            end
          end else begin
            waitCnt <= waitCnt + 8'h01;
          end
        end
        S_VOTE: begin
          if (!(peerSeqOkA && peerSeqOkB)) begin
            crossFault <= 1'b1;
          end
          if (!fallback) begin
            inputWord <= next_inputWord;
            healthWord <= next_healthWord;
          end
          timestamp <= timestamp + 32'h00000001;
          shreg <= {timestamp, MODULE_ID, addr, next_inputWord[15:0],
                    next_healthWord[15:0], status};
          bitCnt <= 8'h00;
          state <= S_SEND;
        end
        S_SEND: begin
          frameValid <= 1'b1;
          frameStart <= (bitCnt == 8'h00);
          if (bitCnt < `FRAME_CRC_FIRST) begin
            frameData <= shreg[95];
            shreg <= {shreg[94:0], 1'b0};
          end else begin
            frameData <= crcOut[~bitCnt[4:0]];
          end
          // Data plus CRC stay at 128 bits, under the 160-bit ceiling
          if (bitCnt == `FRAME_LAST_BIT) begin
            state <= S_IDLE;
          end else begin
            bitCnt <= bitCnt + 8'h01;
          end
        end
        default: begin
          state <= S_IDLE;
        end
      endcase
    end
  end
endmodule // dual_channel_safety_input_diag

// ===== verification/dual_channel_safety_input_diag_checker.sv
// Purpose: Port checker of the safety input diagnostics
// Assumes: One clock, synchronous reset
// Notes: Bound to every instance of the top module
`timescale 1ns/1ps
module dual_channel_safety_input_diag_checker #(
  parameter NCH = 16
) (
  // Clock and reset
  input wire core_clk,
  input wire rst,
  // Inputs watched
  input wire backplaneOver,
  input wire backplaneUnder,
  input wire procTestOk,
  input wire sysTestOk,
  input wire ltDone,
  input wire ltClockOk,
  input wire ltMemOk,
  input wire ltCtrlOk,
  input wire dpmAccess,
  input wire [15:0] dpmWordA,
  input wire [15:0] dpmWordB,
  // Outputs watched
  input wire sampleStrobe,
  input wire [NCH-1:0] forceEnA,
  input wire [NCH-1:0] forceEnB,
  input wire running,
  input wire fallback,
  input wire moduleHealthy,
  input wire [NCH-1:0] inputWord,
  input wire [NCH-1:0] healthWord,
  input wire [NCH-1:0] diagFault,
  input wire [NCH-1:0] openWire,
  input wire frameStart,
  input wire frameValid
);
  reg [7:0] bitCount;
  always @(posedge core_clk) begin
    if (rst)
      bitCount <= 8'h00;
    else if (frameValid)
      bitCount <= bitCount + 8'h01;
    else
      bitCount <= 8'h00;
  end
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);
  // Pins pass a synchroniser first, hence eight cycles
  sequence bpFault;
    (backplaneOver || backplaneUnder) [*8];
  endsequence
  sequence frameOpen;
    frameStart && frameValid;
  endsequence
  sequence ltBad;
    ltDone && !(ltClockOk && ltMemOk && ltCtrlOk);
  endsequence
  fallback_entry_a: assert property (bpFault |-> fallback)
    else $error("fallback not taken");
  fallback_zero_a: assert property (fallback && $past(fallback, 3) |-> inputWord == 0)
    else $error("inputs not zero in fallback");
  idle_zero_a: assert property (!running |-> inputWord == 0 && healthWord == 0)
    else $error("data reported before start");
  strobe_gate_a: assert property (sampleStrobe |-> $past(running) && !$past(sampleStrobe))
    else $error("sampling strobe misplaced");
  force_uniform_a: assert property ((forceEnA == 0 || &forceEnA) && (forceEnB == 0 || &forceEnB))
    else $error("force enables split");
  frame_length_a: assert property ($fell(frameValid) |-> bitCount == 8'h80)
    else $error("frame length wrong");
  frame_max_a: assert property (bitCount <= 8'ha0)
    else $error("frame too long");
  frame_open_a: assert property (frameOpen |-> bitCount == 8'h00 && $past(running))
    else $error("frame start misplaced");
  diag_clear_a: assert property ($changed(healthWord) |-> (healthWord & diagFault) == 0)
    else $error("faulty channel healthy");
  open_clear_a: assert property ($changed(healthWord) |-> (healthWord & openWire) == 0)
    else $error("open wire channel healthy");
  chan_health_a: assert property ($changed(healthWord) && healthWord != 0 |->
    moduleHealthy || $past(moduleHealthy))
    else $error("channel healthy in sick module");
  lt_fault_a: assert property (ltBad |-> ##[1:450] !moduleHealthy)
    else $error("long-term fault ignored");
  dpm_fault_a: assert property (dpmAccess && dpmWordA != dpmWordB |-> ##[1:450] !moduleHealthy)
    else $error("memory copy mismatch ignored");
  po_result_a: assert property ($rose(running) |-> $past(procTestOk) && $past(sysTestOk))
    else $error("started without passing tests");
endmodule // dual_channel_safety_input_diag_checker

bind dual_channel_safety_input_diag dual_channel_safety_input_diag_checker #(.NCH(NCH))
  chk (.*);

// ===== verification/safety_cpu_model.sv
// Purpose: Safety CPU end of the response frame link
// Assumes: 96 data bits then 32 CRC bits, MSB first
// Notes: corrupt flips bits on receipt, standing in for line disturbance
`timescale 1ns/1ps
`include "safety_di_consts.vh"
module safety_cpu_model #(
  parameter MAX_ERR = 2
) (
  // Clock and reset
  input wire core_clk,
  input wire rst,
  // Frame link
  input wire frameStart,
  input wire frameValid,
  input wire frameData,
  input wire corrupt,
  // Received frame
  output reg gotFrame,
  output reg [7:0] frameBits,
  output reg [127:0] frameWord,
  output reg crcOk,
  output reg commFail
);
  reg [31:0] crc;
  reg [1:0] errRun;
  reg busy;
  wire rxBit = frameData ^ corrupt;
  wire [7:0] idx = frameStart ? 8'h00 : frameBits;
  wire [31:0] crcIn = frameStart ? `CRC_INIT : crc;
  wire crcMatch = frameWord[31:0] == crc;
  always @(posedge core_clk) begin
    gotFrame <= 1'b0;
    if (rst) begin
      frameBits <= 8'h00;
      errRun <= 2'h0;
      commFail <= 1'b0;
      busy <= 1'b0;
    end else if (frameValid) begin
      busy <= 1'b1;
      frameBits <= idx + 8'h01;
      frameWord <= {frameWord[126:0], rxBit};
      if (idx < `FRAME_CRC_FIRST)
        crc <= {crcIn[30:0], 1'b0} ^ ((crcIn[31] ^ rxBit) ? `CRC_POLY : 32'h0);
    end else if (busy) begin
      busy <= 1'b0;
      gotFrame <= 1'b1;
      crcOk <= crcMatch;
      if (crcMatch)
        errRun <= 2'h0;
      else if (errRun != 2'h3)
        errRun <= errRun + 2'h1;
      // Link failure is final; only a reset restores it
      if (!crcMatch && {1'b0, errRun} + 3'h1 >= MAX_ERR)
        commFail <= 1'b1;
    end
  end
endmodule // safety_cpu_model

// ===== verification/dual_channel_safety_input_diag_test.sv
// Purpose: Self-checking bench of the safety input diagnostics
// Assumes: Shortened counts; bench plays field, supplies and test results
// Notes: Seed fixed, so a failing run repeats exactly
`timescale 1ns/1ps
`define CHK(a, e) \
  begin \
    checkCount = checkCount + 1; \
    if ((a) !== (e)) begin \
      badCount = badCount + 1; \
      $display("MISMATCH t=%0t got=%h exp=%h", $time, (a), (e)); \
    end \
  end
module dual_channel_safety_input_diag_test;
  localparam NCH = 16;
  // Arbitrary identity value
  localparam [15:0] MOD_ID = 16'h3c96;
  // Shortened counts so the run stays brief
  localparam MODCYC = 400, PO_PROC = 20, PO_SYS = 30, LT_CYC = 5, SOLO_CYC = 6, INTER_CYC = 2;
  localparam MAX_ERR = 2;
  reg core_clk, rst, sensorSupplyA, sensorSupplyB, backplaneOver, backplaneUnder;
  reg procTestOk, sysTestOk, ltOk, ltDone, dpmAccess, corrupt, soloA, soloB, both;
  reg procSupplyA, procSupplyB, peerSeqOkA, peerSeqOkB;
  reg [NCH-1:0] chainA, chainB, valA, valB, leak, stuck;
  reg [15:0] dpmWordA, dpmWordB, v, m, i1, h1;
  reg [7:0] slotAddr;
  reg [2:0] ltPipe;
  reg [3:0] k;
  reg [31:0] r, ts;
  reg [127:0] fw;
  integer badCount, checkCount, frameCount, seed, i, n;
  wire sampleStrobe, forceLevel, ltStart, running, fallback, moduleHealthy;
  wire frameStart, frameValid, frameData, gotFrame, crcOk, commFail;
  wire [NCH-1:0] forceEnA, forceEnB, inputWord, healthWord, diagFault, openWire;
  wire [7:0] frameBits;
  wire [127:0] frameWord;
  dual_channel_safety_input_diag #(.NCH(NCH), .MODCYC_CLKS(MODCYC), .PO_PROC_CLKS(PO_PROC),
    .PO_SYS_CLKS(PO_SYS), .LT_MODCYC(LT_CYC), .SOLO_MODCYC(SOLO_CYC),
    .INTER_MODCYC(INTER_CYC), .MODULE_ID(MOD_ID)
  ) DUT (.core_clk(core_clk), .rst(rst), .chainA(chainA), .chainB(chainB),
    .leakSense(leak), .sensorSupplyA(sensorSupplyA), .sensorSupplyB(sensorSupplyB),
    .procSupplyA(procSupplyA), .procSupplyB(procSupplyB), .backplaneOver(backplaneOver),
    .backplaneUnder(backplaneUnder), .slotAddr(slotAddr), .procTestOk(procTestOk),
    .sysTestOk(sysTestOk), .peerSeqOkA(peerSeqOkA), .peerSeqOkB(peerSeqOkB), .ltDone(ltDone),
    .ltClockOk(ltOk), .ltMemOk(ltOk), .ltCtrlOk(ltOk), .dpmAccess(dpmAccess),
    .dpmWordA(dpmWordA), .dpmWordB(dpmWordB), .sampleStrobe(sampleStrobe),
    .forceEnA(forceEnA), .forceEnB(forceEnB), .forceLevel(forceLevel), .ltStart(ltStart),
    .running(running), .fallback(fallback), .moduleHealthy(moduleHealthy),
    .inputWord(inputWord), .healthWord(healthWord), .diagFault(diagFault),
    .openWire(openWire), .frameStart(frameStart), .frameValid(frameValid),
    .frameData(frameData));
  safety_cpu_model #(.MAX_ERR(MAX_ERR)) cpu (.core_clk(core_clk), .rst(rst),
    .frameStart(frameStart), .frameValid(frameValid), .frameData(frameData),
    .corrupt(corrupt), .gotFrame(gotFrame), .frameBits(frameBits),
    .frameWord(frameWord), .crcOk(crcOk), .commFail(commFail));
  initial begin
    core_clk = 1'b0;
    forever #20 core_clk = ~core_clk;
  end
  // Field side: forced chains echo the forced level unless a bit is stuck
  always @(posedge core_clk) begin
    chainA <= (forceEnA != 0) ? ({NCH{forceLevel}} & ~stuck) | (valA & stuck) : valA;
    chainB <= (forceEnB != 0) ? ({NCH{forceLevel}} & ~stuck) | (valB & stuck) : valB;
    ltPipe <= {ltPipe[1:0], ltStart};
    ltDone <= ltPipe[2];
    if (rst) begin
      {soloA, soloB, both} <= 3'h0;
      frameCount <= 0;
    end else begin
      soloA <= soloA | (forceEnA != 0 && forceEnB == 0);
      soloB <= soloB | (forceEnB != 0 && forceEnA == 0);
      both <= both | (forceEnA != 0 && forceEnB != 0);
      frameCount <= frameCount + (gotFrame ? 1 : 0);
    end
  end
  task conclude;
    begin
      $display("checks %0d, mismatches %0d", checkCount, badCount);
      if (badCount == 0 && checkCount > 0)
        $display("All checks passed");
      else
        $display("Checks failed");
      $finish;
    end
  endtask
  task endTest(input [8*8-1:0] nm);
    $display("test %0s done, checks %0d, mismatches %0d", nm, checkCount, badCount);
  endtask
  task doReset;
    begin
      @(posedge core_clk);
      rst <= 1'b1;
      repeat (20) @(posedge core_clk);
      rst <= 1'b0;
    end
  endtask
  task waitRun;
    begin
      n = 0;
      while (running !== 1'b1 && n < 300) begin
        @(negedge core_clk);
        n = n + 1;
      end
      `CHK(running, 1'b1)
    end
  endtask
  task getFrame;
    begin
      n = 0;
      @(negedge core_clk);
      while (gotFrame !== 1'b1 && n < 1000) begin
        @(negedge core_clk);
        n = n + 1;
      end
      `CHK(gotFrame, 1'b1)
      fw = frameWord;
    end
  endtask
  task setField(input [15:0] a, input [15:0] b, input [15:0] l);
    begin
      @(posedge core_clk);
      valA <= a;
      valB <= b;
      leak <= l;
    end
  endtask
  task dpmPoke(input [15:0] a, input [15:0] b);
    begin
      @(posedge core_clk);
      dpmAccess <= 1'b1;
      dpmWordA <= a;
      dpmWordB <= b;
      @(posedge core_clk);
      dpmAccess <= 1'b0;
    end
  endtask
  initial begin
    repeat (60000) @(posedge core_clk);
    badCount = badCount + 1;
    conclude;
  end
  initial begin
    {rst, backplaneOver, backplaneUnder, procTestOk, dpmAccess, corrupt} = 6'h20;
    {sensorSupplyA, sensorSupplyB, sysTestOk, ltOk} = 4'hf;
    {procSupplyA, procSupplyB, peerSeqOkA, peerSeqOkB} = 4'hf;
    {valA, valB, stuck, dpmWordA, dpmWordB} = 80'h0;
    leak = 16'hffff;
    badCount = 0;
    checkCount = 0;
    seed = $urandom(11425);
    r = $urandom;
    slotAddr = r[7:0];
    doReset;
    repeat (100) @(posedge core_clk);
    @(negedge core_clk);
    `CHK(running, 1'b0)
    `CHK(inputWord, 16'h0000)
    endTest("pofail");
    @(posedge core_clk);
    procTestOk <= 1'b1;
    sensorSupplyB <= 1'b0;
    doReset;
    repeat (100) @(posedge core_clk);
    @(negedge core_clk);
    `CHK(running, 1'b0)
    @(posedge core_clk);
    sensorSupplyB <= 1'b1;
    repeat (20) @(posedge core_clk);
    @(negedge core_clk);
    `CHK(running, 1'b0)
    waitRun;
    endTest("poweron");
    getFrame;
    for (i = 0; i < 5; i = i + 1) begin
      r = $urandom;
      v = (i == 0) ? 16'h0000 : (i == 1) ? 16'hffff : r[15:0];
      ts = fw[127:96];
      setField(v, v, 16'hffff);
      dpmPoke(r[31:16], r[31:16]);
      getFrame;
      `CHK(fw[71:56], v)
      `CHK(fw[55:40], 16'hffff)
      `CHK(inputWord, v)
      `CHK({crcOk, frameBits, fw[35]}, 10'h300)
      `CHK({fw[95:72], fw[39]}, {MOD_ID, slotAddr, 1'b1})
      `CHK(fw[127:96] > ts, 1'b1)
      `CHK(moduleHealthy, 1'b1)
    end
    endTest("vote");
    r = $urandom;
    m = r[15:0] | 16'h0001;
    setField(r[31:16], r[31:16] ^ m, 16'hffff);
    getFrame;
    i1 = fw[71:56];
    h1 = fw[55:40];
    getFrame;
    `CHK(i1 & fw[71:56] & m, 16'h0000)
    `CHK(h1 & fw[55:40] & m, 16'h0000)
    `CHK(fw[55:40] & ~m, ~m)
    r = $urandom;
    k = r[3:0];
    setField(r[31:16], r[31:16], ~(16'h0001 << k));
    getFrame;
    `CHK(fw[55:40], ~(16'h0001 << k))
    `CHK(openWire, 16'h0001 << k)
    endTest("discrep");
    setField(r[31:16], r[31:16], 16'hffff);
    stuck <= 16'h0100;
    repeat (6) getFrame;
    `CHK(diagFault, 16'h0100)
    `CHK(fw[55:40], 16'hfeff)
    `CHK({soloA, soloB, both}, 3'h7)
    @(posedge core_clk);
    corrupt <= 1'b1;
    getFrame;
    `CHK({crcOk, commFail}, 2'h0)
    getFrame;
    `CHK(commFail, 1'b1)
    @(posedge core_clk);
    corrupt <= 1'b0;
    ltOk <= 1'b0;
    repeat (6) getFrame;
    `CHK({moduleHealthy, fw[35]}, 2'h1)
    `CHK(fw[55:40], 16'h0000)
    endTest("faults");
    @(posedge core_clk);
    ltOk <= 1'b1;
    stuck <= 16'h0000;
    doReset;
    waitRun;
    getFrame;
    @(posedge core_clk);
    {procSupplyA, peerSeqOkB} <= 2'b00;
    dpmPoke(16'h1234, 16'h1235);
    repeat (2) getFrame;
    `CHK({moduleHealthy, fw[37:34]}, 5'h0c)
    @(posedge core_clk);
    {procSupplyA, peerSeqOkB} <= 2'b11;
    for (i = 0; i < 2; i = i + 1) begin
      doReset;
      waitRun;
      @(posedge core_clk);
      {backplaneOver, backplaneUnder} <= (i == 0) ? 2'b10 : 2'b01;
      repeat (20) @(posedge core_clk);
      @(negedge core_clk);
      `CHK({fallback, inputWord}, 17'h10000)
      n = frameCount;
      repeat (600) @(posedge core_clk);
      `CHK(frameCount, n)
      {backplaneOver, backplaneUnder} <= 2'b00;
    end
    endTest("fallback");
    conclude;
  end
endmodule // dual_channel_safety_input_diag_test
